/* shared/crcu_params.svh */
// Register offsets, field positions, reset values and timing counts of the checksum unit
`ifndef CRCU_PARAMS_SVH
`define CRCU_PARAMS_SVH

// Register byte offsets
`define CRCU_OFS_DATA      12'h000
`define CRCU_OFS_SCRATCH   12'h004
`define CRCU_OFS_CTRL      12'h008
`define CRCU_OFS_SEED      12'h010

// Control register field positions
`define CRCU_CTRL_RST_BIT     0
`define CRCU_CTRL_INREV_LSB   5
`define CRCU_CTRL_INREV_MSB   6
`define CRCU_CTRL_OUTREV_BIT  7

// Reset values
`define CRCU_DATA_RST     32'hffffffff
`define CRCU_SEED_RST     32'hffffffff
`define CRCU_SCRATCH_RST  8'h00

// Generator polynomial, fixed
`define CRCU_POLY         32'h04c11db7

// Longest update, in bus clock cycles
`define CRCU_CALC_CYCLES  4

// Access size levels and reversal modes
`define CRCU_LVL_BYTE     2'h1
`define CRCU_LVL_HALF     2'h2
`define CRCU_LVL_WORD     2'h3
`define CRCU_REV_WORD     2'h3

`endif

/* shared/crcu_pkg.sv */
// Types shared by the checksum unit modules
package crcu_pkg;

  // Engine states, Gray coded
  typedef enum logic [0:0]
  {
    CRCU_ENG_IDLE = 1'b0,
    CRCU_ENG_RUN  = 1'b1
  } crcu_eng_st_t;

  // Engine state
  typedef struct packed
  {
    crcu_eng_st_t st;
    logic [31:0]  crc;
    logic [31:0]  shreg;
    logic [2:0]   left;
  } crcu_eng_t;

  // Size level plus low-aligned write data
  typedef struct packed
  {
    logic [1:0]  lvl;
    logic [31:0] data;
  } crcu_wr_t;

  // Register slice state
  typedef struct packed
  {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        buf_full;
    logic [31:0] buf_data;
    logic [1:0]  buf_lvl;
    logic [7:0]  scratch;
    logic [1:0]  in_rev;
    logic        out_rev;
    logic [31:0] seed;
  } crcu_regs_t;

endpackage : crcu_pkg

/* hdl/crcu_bitrev.sv */
// Bit order reversal within bytes, half words or the whole word
`timescale 1ns/10ps
`include "crcu_params.svh"

module crcu_bitrev
(
  // Data
  input  wire logic [31:0] din,
  input  wire logic [1:0]  mode,
  input  wire logic [1:0]  lvl,
  output logic      [31:0] dout
);

  logic [1:0] eff;

  ////////////////////////////////////////////////////////////////////////////////
  // Clamp the mode to the access size, so a narrow write reverses only itself
  always_comb
  begin
    eff = (mode > lvl) ? lvl : mode;
  end

  // Mirror bits inside groups of 8, 16 or 32
  always_comb
  begin
    dout = din;
    for (int i = 0; i < 32; i++)
    begin
      unique case (eff)
        2'h0: dout[i] = din[i];
        2'h1: dout[i] = din[(i & ~7) + (7 - (i & 7))];
        2'h2: dout[i] = din[(i & ~15) + (15 - (i & 15))];
        2'h3: dout[i] = din[31 - i];
      endcase
    end
  end

endmodule : crcu_bitrev

/* hdl/crcu_engine.sv */
// Running remainder and byte-serial update engine
`timescale 1ns/10ps
`include "crcu_params.svh"

module crcu_engine
  import crcu_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // Control
  input  wire logic        load,
  input  wire logic [31:0] load_val,
  input  wire logic        start,
  input  wire logic [31:0] data,
  input  wire logic [1:0]  lvl,
  // Status
  output logic             busy,
  output logic      [31:0] crc
);

  crcu_eng_t q;
  crcu_eng_t d;

  ////////////////////////////////////////////////////////////////////////////////
  // One byte through the shift register, most significant bit first
  function automatic logic [31:0] crc_step8(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {b, 24'h000000};
    for (int i = 0; i < 8; i++)
    begin
      r = r[31] ? ({r[30:0], 1'b0} ^ `CRCU_POLY) : {r[30:0], 1'b0};
    end
    return r;
  endfunction : crc_step8

  // Bytes per access size
  function automatic logic [2:0] lvl_bytes(input logic [1:0] l);
    logic [2:0] n;
    unique case (l)
      `CRCU_LVL_BYTE: n = 3'h1;
      `CRCU_LVL_HALF: n = 3'h2;
      default:        n = 3'h4;
    endcase
    return n;
  endfunction : lvl_bytes

  ////////////////////////////////////////////////////////////////////////////////
  // Next state: one byte a cycle, at most four cycles a word
  always_comb
  begin
    d = q;
    unique case (q.st)
      CRCU_ENG_IDLE:
      begin
        if (load)
        begin
          d.crc = load_val;
        end
        else if (start)
        begin
          d.shreg = data << (6'd32 - {lvl_bytes(lvl), 3'h0});
          d.left  = lvl_bytes(lvl);
          d.st    = CRCU_ENG_RUN;
        end
      end
      CRCU_ENG_RUN:
      begin
        d.crc   = crc_step8(q.crc, q.shreg[31:24]);
        d.shreg = {q.shreg[23:0], 8'h00};
        d.left  = q.left - 3'h1;
        if (q.left == 3'h1)
        begin
          d.st = CRCU_ENG_IDLE;
        end
      end
    endcase
  end

  // State register, frozen while clk_en is low
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= '{st: CRCU_ENG_IDLE, crc: `CRCU_DATA_RST, shreg: 32'h00000000, left: 3'h0};
    end
    else if (clk_en)
    begin
      q <= d;
    end
  end

  assign busy = (q.st == CRCU_ENG_RUN);
  assign crc  = q.crc;

endmodule : crcu_engine

/* hdl/crcu_top.sv */
// Checksum unit: APB register slice, input buffer, reversal and update engine
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`include "crcu_params.svh"

module crcu_top
  import crcu_pkg::*;
#(
  parameter int unsigned ADDR_W = 12
)
(
  // Clock, reset, enable
  input  wire logic              sys_clk,
  input  wire logic              rst_b,
  input  wire logic              clk_en,
  // APB request
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  // APB answer
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr
);

  crcu_regs_t  q;
  crcu_regs_t  d;
  crcu_wr_t    wr;
  logic [31:0] wr_rev;
  logic [31:0] crc_now;
  logic [31:0] crc_mirror;
  logic [31:0] result_view;
  logic        eng_busy;
  logic        eng_start;
  logic        eng_load;
  logic        access;
  logic        eng_idle;
  logic        data_wr_ok;
  logic        lane0_wr;
  logic        rst_req;
  logic        rst_ok;
  logic [31:0] ctrl_view;

  // Register offsets at the width of the address bus
  localparam logic [ADDR_W-1:0] OFS_DATA    = ADDR_W'(`CRCU_OFS_DATA);
  localparam logic [ADDR_W-1:0] OFS_SCRATCH = ADDR_W'(`CRCU_OFS_SCRATCH);
  localparam logic [ADDR_W-1:0] OFS_CTRL    = ADDR_W'(`CRCU_OFS_CTRL);
  localparam logic [ADDR_W-1:0] OFS_SEED    = ADDR_W'(`CRCU_OFS_SEED);

  // Register slice contents after reset
  localparam crcu_regs_t REGS_RST = '{pready:   1'b0,
                                      pslverr:  1'b0,
                                      prdata:   32'h00000000,
                                      buf_full: 1'b0,
                                      buf_data: 32'h00000000,
                                      buf_lvl:  `CRCU_LVL_WORD,
                                      scratch:  `CRCU_SCRATCH_RST,
                                      in_rev:   2'h0,
                                      out_rev:  1'b0,
                                      seed:     `CRCU_SEED_RST};

  ////////////////////////////////////////////////////////////////////////////////
  // Write size and lane selection from the byte strobes
  function automatic crcu_wr_t lane_pick(input logic [3:0] strb, input logic [31:0] wd);
    crcu_wr_t r;
    unique case (strb)
      4'h1:    r = '{lvl: `CRCU_LVL_BYTE, data: {24'h000000, wd[7:0]}};
      4'h2:    r = '{lvl: `CRCU_LVL_BYTE, data: {24'h000000, wd[15:8]}};
      4'h4:    r = '{lvl: `CRCU_LVL_BYTE, data: {24'h000000, wd[23:16]}};
      4'h8:    r = '{lvl: `CRCU_LVL_BYTE, data: {24'h000000, wd[31:24]}};
      4'h3:    r = '{lvl: `CRCU_LVL_HALF, data: {16'h0000, wd[15:0]}};
      4'hc:    r = '{lvl: `CRCU_LVL_HALF, data: {16'h0000, wd[31:16]}};
      default: r = '{lvl: `CRCU_LVL_WORD, data: wd};
    endcase
    return r;
  endfunction : lane_pick

  // Byte lane enabled by the strobes; an all-zero strobe means a full word
  function automatic logic lane_on(input logic [3:0] strb, input int lane);
    logic r;
    r = strb[lane] || (strb == 4'h0);
    return r;
  endfunction : lane_on

  // Byte-masked update of a register word
  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (lane_on(strb, i))
      begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : wmask

  ////////////////////////////////////////////////////////////////////////////////
  // Input side: pick the lane, then reverse per control field
  assign wr = lane_pick(pstrb, pwdata);

  crcu_bitrev u_in_rev
  (
    .din  (wr.data),
    .mode (q.in_rev),
    .lvl  (wr.lvl),
    .dout (wr_rev)
  );

  // Output side: whole-word mirror of the remainder
  crcu_bitrev u_out_rev
  (
    .din  (crc_now),
    .mode (`CRCU_REV_WORD),
    .lvl  (`CRCU_LVL_WORD),
    .dout (crc_mirror)
  );

  assign result_view = q.out_rev ? crc_mirror : crc_now;

  // Update engine holding the running remainder
  crcu_engine u_engine
  (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .load     (eng_load),
    .load_val (q.seed),
    .start    (eng_start),
    .data     (q.buf_data),
    .lvl      (q.buf_lvl),
    .busy     (eng_busy),
    .crc      (crc_now)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Access phase waiting for an answer
  assign access = psel && penable && !q.pready;

  // Buffer and engine both empty: the result is final, a reseed loses nothing
  assign eng_idle = !q.buf_full && !eng_busy;

  // The buffered word moves to the engine as soon as the engine is free
  assign eng_start = q.buf_full && !eng_busy;

  // A data write fits if the buffer is empty or empties in this cycle
  assign data_wr_ok = !q.buf_full || eng_start;

  // Control write to byte 0; a reseed waits until pending data is folded in
  assign lane0_wr = lane_on(pstrb, 0);
  assign rst_req  = lane0_wr && pwdata[`CRCU_CTRL_RST_BIT];
  assign rst_ok   = !rst_req || eng_idle;

  // Control read back: reversal fields in place, reset bit always zero
  assign ctrl_view = {24'h000000, q.out_rev, q.in_rev, 5'h00};

  // Register slice, buffer drain and answer generation
  always_comb
  begin
    d         = q;
    d.pready  = 1'b0;
    d.pslverr = 1'b0;
    eng_load  = 1'b0;

    // Hand the buffered word to the engine once it is idle
    if (eng_start)
    begin
      d.buf_full = 1'b0;
    end

    // Decode the waiting access by register offset
    if (access)
    begin
      unique case (paddr)
        // Data: words into the buffer, result out once final
        OFS_DATA:
        begin
          if (pwrite)
          begin
            // Buffer free now, or freed this cycle; otherwise wait states
            if (data_wr_ok)
            begin
              d.buf_full = 1'b1;
              d.buf_data = wr_rev;
              d.buf_lvl  = wr.lvl;
              d.prdata   = 32'h00000000;
              d.pready   = 1'b1;
            end
          end
          else if (eng_idle)
          begin
            d.prdata = result_view;
            d.pready = 1'b1;
          end
        end
        // Scratch byte: lane 0 only, outside any calculation
        OFS_SCRATCH:
        begin
          if (pwrite)
          begin
            if (lane0_wr)
            begin
              d.scratch = pwdata[7:0];
            end
            d.prdata  = 32'h00000000;
          end
          else
          begin
            d.prdata = {24'h000000, q.scratch};
          end
          d.pready = 1'b1;
        end
        // Control: reversal fields and the self-clearing reseed bit
        OFS_CTRL:
        begin
          if (pwrite)
          begin
            // A reset waits for pending data so no word is lost or misordered
            if (rst_ok)
            begin
              if (lane0_wr)
              begin
                d.in_rev  = pwdata[`CRCU_CTRL_INREV_MSB:`CRCU_CTRL_INREV_LSB];
                d.out_rev = pwdata[`CRCU_CTRL_OUTREV_BIT];
                eng_load  = pwdata[`CRCU_CTRL_RST_BIT];
              end
              d.prdata = 32'h00000000;
              d.pready = 1'b1;
            end
          end
          else
          begin
            d.prdata = ctrl_view;
            d.pready = 1'b1;
          end
        end
        // Seed: byte-masked word, loaded into the remainder by a reseed
        OFS_SEED:
        begin
          if (pwrite)
          begin
            d.seed   = wmask(q.seed, pwdata, pstrb);
            d.prdata = 32'h00000000;
          end
          else
          begin
            d.prdata = q.seed;
          end
          d.pready = 1'b1;
        end
        default:
        begin
          // Unmapped: answer at once with an error and zero data
          d.prdata  = 32'h00000000;
          d.pslverr = 1'b1;
          d.pready  = 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register, frozen while clk_en is low
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      q <= REGS_RST;
    end
    else if (clk_en)
    begin
      q <= d;
    end
  end

  // Answer ports straight from the state register
  assign pready  = q.pready;
  assign prdata  = q.prdata;
  assign pslverr = q.pslverr;

endmodule : crcu_top

/* verif/crcu_apb_mst.sv */
// APB master model standing in for the processor core
`timescale 1ns/10ps
module crcu_apb_mst
(
  // Clock and answer
  input  wire logic        sys_clk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  // Request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb
);
  // Idle bus at time zero
  initial
  begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
    pstrb <= 4'h0;
  end

  // One transfer: setup, access held until pready, then release and one idle cycle
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge sys_clk);
  endtask : xfer
endmodule : crcu_apb_mst

/* verif/crcu_monitor.sv */
// Bus timing and field checks on the checksum unit ports
`timescale 1ns/10ps
`include "crcu_params.svh"
module crcu_mon
#(
  parameter int unsigned ADDR_W = 12
)
(
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst_b,
  input wire logic              clk_en,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  localparam logic [ADDR_W-1:0] A_D = `CRCU_OFS_DATA;
  localparam logic [ADDR_W-1:0] A_S = `CRCU_OFS_SCRATCH;
  localparam logic [ADDR_W-1:0] A_C = `CRCU_OFS_CTRL;
  localparam logic [ADDR_W-1:0] A_I = `CRCU_OFS_SEED;
  logic req;
  logic hit;
  // Access phase waiting and address decode
  assign req = psel && penable && !pready && clk_en;
  assign hit = paddr == A_D || paddr == A_S || paddr == A_C || paddr == A_I;
  sequence s_data_rd;
    req && !pwrite && paddr == A_D;
  endsequence
  sequence s_word_wr_done;
    pready && psel && pwrite && paddr == A_D && pstrb == 4'hf;
  endsequence
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_unmapped_err: assert property (req && !hit |=> pready && pslverr && prdata == 0) else $error("bad unmapped");
  a_mapped_no_err: assert property (pready && psel && hit |-> !pslverr) else $error("error on mapped reg");
  a_write_bound: assert property (req && pwrite && paddr == A_D |-> ##[1:8] pready) else $error("write hung");
  a_read_bound: assert property (s_data_rd |-> ##[1:12] pready) else $error("result read hung");
  a_read_stall: assert property (s_word_wr_done |-> ##1 !(pready && !pwrite && paddr == A_D)[*5])
    else $error("result read before update ended");
  a_ctrl_fields: assert property (pready && !pwrite && paddr == A_C |-> prdata[31:8] == 0 && prdata[4:0] == 0)
    else $error("control reads reserved or reset bit");
  a_scratch_byte: assert property (pready && !pwrite && paddr == A_S |-> prdata[31:8] == 0)
    else $error("scratch upper bits set");
  a_rdata_holds: assert property (!pready |-> $stable(prdata)) else $error("prdata moved between answers");
endmodule : crcu_mon

bind crcu_top crcu_mon #(.ADDR_W(ADDR_W)) u_mon (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .prdata(prdata), .pslverr(pslverr));

/* verif/tb_top.sv */
// Self-checking testbench of the checksum unit
`timescale 1ns/10ps
`include "crcu_params.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; $display("mismatch %s exp %h saw %h", n, e, g); end end
module tb_top;
  import crcu_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_b;
  logic        clk_en;
  logic        psel, penable, pwrite, pready, pslverr, errv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv, d, dv, crc_m;
  logic [3:0]  pstrb;
  int          error_cnt, samples_checked, w;
  logic [3:0]  stb [4] = '{4'h1, 4'h2, 4'hc, 4'hf};
  int          nb [4] = '{8, 8, 16, 32};
  int          sh [4] = '{0, 8, 16, 0};

  ////////////////////////////////////////////////////////////////////////////////
  always #12.5 sys_clk = ~sys_clk;

  crcu_top #(.ADDR_W(12)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));
  crcu_apb_mst u_mst (.sys_clk(sys_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

  ////////////////////////////////////////////////////////////////////////////////
  // Mirror bits within chunks of w bits
  function automatic logic [31:0] mir(input logic [31:0] x, input int w);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[(i / w) * w + w - 1 - i % w] = x[i];
    return r;
  endfunction : mir

  // Fold n bits into the remainder, most significant first
  function automatic logic [31:0] upd(input logic [31:0] c, input logic [31:0] x, input int n);
    for (int i = n - 1; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ x[i]) ? `CRCU_POLY : 32'h0);
    return c;
  endfunction : upd

  task automatic wr(input logic [11:0] a, input logic [31:0] x, input logic [3:0] s);
    u_mst.xfer(1'b1, a, x, s, rdv, errv);
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input string n);
    u_mst.xfer(1'b0, a, 32'h0, 4'hf, rdv, errv);
    `CHK(n, e, rdv)
  endtask : rdchk

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    #125000;
    error_cnt++;
    test_done;
  end

  // Main sequence
  initial
  begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    rdchk(`CRCU_OFS_DATA, 32'hffffffff, "data_rst");
    rdchk(`CRCU_OFS_SEED, 32'hffffffff, "seed_rst");
    rdchk(`CRCU_OFS_SCRATCH, 32'h0, "scratch_rst");
    rdchk(`CRCU_OFS_CTRL, 32'h0, "ctrl_rst");
    u_mst.xfer(1'b0, 12'h00c, 32'h0, 4'hf, rdv, errv);
    `CHK("unmapped_err", 1'b1, errv)
    $display("test reset_map done");
    wr(`CRCU_OFS_SCRATCH, 32'h5a5aa5c3, 4'hf);
    wr(`CRCU_OFS_SEED, 32'h12345678, 4'hf);
    wr(`CRCU_OFS_CTRL, 32'h1, 4'hf);
    crc_m = 32'h12345678;
    rdchk(`CRCU_OFS_DATA, crc_m, "data_seed");
    rdchk(`CRCU_OFS_CTRL, 32'h0, "ctrl_selfclr");
    $display("test seed done");
    for (int m = 0; m < 4; m++)
    begin
      wr(`CRCU_OFS_CTRL, 32'(m) << 5, 4'hf);
      d = 32'hc1a50f3b + 32'(m);
      for (int k = 0; k < 4; k++)
      begin
        wr(`CRCU_OFS_DATA, d, stb[k]);
        dv = 32'((64'(d) >> sh[k]) & ((64'h1 << nb[k]) - 1));
        w = (m == 0) ? 0 : (8 << (m - 1));
        if (w > nb[k]) w = nb[k];
        if (w > 0) dv = mir(dv, w);
        crc_m = upd(crc_m, dv, nb[k]);
      end
      rdchk(`CRCU_OFS_DATA, crc_m, "data_mode");
      $display("test input_reverse %0d done", m);
    end
    wr(`CRCU_OFS_CTRL, 32'h80, 4'hf);
    rdchk(`CRCU_OFS_CTRL, 32'h80, "ctrl_outrev");
    rdchk(`CRCU_OFS_DATA, mir(crc_m, 32), "data_outrev");
    wr(`CRCU_OFS_DATA, 32'h0badf00d, 4'hf);
    wr(`CRCU_OFS_CTRL, 32'h81, 4'hf);
    rdchk(`CRCU_OFS_DATA, mir(32'h12345678, 32), "data_reseed");
    rdchk(`CRCU_OFS_SCRATCH, 32'hc3, "scratch_keep");
    $display("test output_reverse done");
    // Freeze the engine after its first byte step, with three bytes pending; the result must still come out right
    wr(`CRCU_OFS_DATA, 32'h600dcafe, 4'hf);
    clk_en <= 1'b0;
    repeat (6) @(posedge sys_clk);
    clk_en <= 1'b1;
    rdchk(`CRCU_OFS_DATA, mir(upd(32'h12345678, 32'h600dcafe, 32), 32), "data_frozen");
    $display("test clock_enable done");
    test_done;
  end
endmodule : tb_top
